// ### pcw_regs.svh
/*
  constants of the page map and card window decoder: page numbers,
  decoded offsets on the status page, status bit positions.
  assumes a host with 8-bit pages and a 16-bit address per page.
*/
`ifndef PCW_REGS_SVH
`define PCW_REGS_SVH

// swappable page groups
`define PCW_PAGE_LO_FIRST 8'h01
`define PCW_PAGE_LO_LAST 8'h03
`define PCW_PAGE_HI_FIRST 8'h04
`define PCW_PAGE_HI_LAST 8'h06

// card memory window
`define PCW_CARD_FIRST 8'h80
`define PCW_CARD_LAST 8'hBF

// status page and its decoded locations
`define PCW_STAT_PAGE 8'h30
`define PCW_STAT_OFS 16'h0000
`define PCW_BANK_OFS 16'h0001
`define PCW_MAP_OFS 16'h0002

// layout latch values and reset values
`define PCW_MAP_STD 1'b0
`define PCW_MAP_DL 1'b1
`define PCW_BANK_RST 5'h00

// address bit that leaves the 32 Kbyte paged window
`define PCW_WIN_BIT 15

// card status byte bit positions
`define PCW_ST_DET0 0
`define PCW_ST_DET1 1
`define PCW_ST_BVD0 4
`define PCW_ST_BVD1 5
`define PCW_ST_WAIT 7

`endif

// ### pcw_pkg.sv
/*
  types of the page map and card window decoder.
  assumes pcw_regs.svh for the numeric constants.
*/
package pcw_pkg;

  // one host bus request, sampled on i_clk
  typedef struct packed {
    logic [7:0] page;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } pcw_req_t;

  // complete registered state of the decoder
  typedef struct packed {
    logic map_dl;
    logic [4:0] bank;
    logic flash_sel;
    logic ram_sel;
    logic card_sel;
    logic flash_we;
    logic prog_fail;
    logic rvalid;
    logic [16:0] mem_addr;
    logic [24:0] card_addr;
    logic [7:0] rdata;
  } pcw_state_t;

endpackage : pcw_pkg

// ### pcw_page_map.sv
/*
  page map and card window decoder: routes host pages to the flash and
  ram sockets under a layout latch, decodes the card window with a bank
  field and doubled byte mapping, and answers reads of the card status.
  assumes host requests synchronous to i_clk, one request per cycle,
  never rd and wr together; switch and card inputs already synchronous.
*/
`timescale 1ns/10ps
`include "pcw_regs.svh"

// Behaviour
// - download layout: pages 4-6 to ram socket, pages 1-3 to flash socket
// - standard layout: pages 1-3 to ram socket, pages 4-6 to flash socket
// - layout held in a host-written latch; host reapplies it after reset
// - factory cleanup leaves the standard layout in effect
// - each swappable page is 32 Kbyte; parallel pages share one slot index
// - flash writes only with write-enable and both config switches on
// - five-bit bank field picks one of 32 one-megabyte card banks
// - card window decoded at host pages 80 to BF hex
// - each card byte occupies two consecutive host bytes
// - card status byte read at address 0000 of page 30 hex
// - status bits 0 and 1 show active-low card detect inputs
// - status bits 4 and 5 show battery detect inputs, high when good
// - status bit 7 shows card wait, high when inactive
module pcw_page_map
  import pcw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pcw_req_t i_req,
  input wire logic i_factory_cleanup,
  input wire logic i_sw_flash_we,
  input wire logic i_sw_cfg_a,
  input wire logic i_sw_cfg_b,
  input wire logic [1:0] i_card_detect_n,
  input wire logic [1:0] i_card_bvd,
  input wire logic i_card_wait_n,
  output logic o_map_download,
  output logic [4:0] o_card_bank,
  output logic o_flash_sel,
  output logic o_ram_sel,
  output logic o_card_sel,
  output logic o_flash_we,
  output logic o_prog_fail,
  output logic [16:0] o_mem_addr,
  output logic [24:0] o_card_addr,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid
);

  pcw_state_t st_ff;
  pcw_state_t nxt_st;

  // request classification
  logic acc;
  logic in_win;
  logic pg_lo;
  logic pg_hi;
  logic pg_card;
  logic pg_stat;
  logic to_ram;
  logic prog_ok;
  logic stat_rd;
  logic bank_wr;
  logic map_wr;
  logic [7:0] pg_delta;
  logic [1:0] slot;
  logic [19:0] card_ofs;
  logic [7:0] stat_byte;

  assign acc = i_req.rd | i_req.wr;
  assign in_win = ~i_req.addr[`PCW_WIN_BIT];
  assign pg_lo = (i_req.page >= `PCW_PAGE_LO_FIRST) &&
                 (i_req.page <= `PCW_PAGE_LO_LAST);
  assign pg_hi = (i_req.page >= `PCW_PAGE_HI_FIRST) &&
                 (i_req.page <= `PCW_PAGE_HI_LAST);
  assign pg_card = (i_req.page >= `PCW_CARD_FIRST) &&
                   (i_req.page <= `PCW_CARD_LAST);
  assign pg_stat = (i_req.page == `PCW_STAT_PAGE);
  // ram gets the low group in standard, the high group in download
  assign to_ram = pg_lo ^ st_ff.map_dl;
  // all three switches must be on to program flash
  assign prog_ok = i_sw_flash_we & i_sw_cfg_a & i_sw_cfg_b;
  assign stat_rd = i_req.rd && in_win && pg_stat &&
                   (i_req.addr == `PCW_STAT_OFS);
  assign bank_wr = i_req.wr && in_win && pg_stat &&
                   (i_req.addr == `PCW_BANK_OFS);
  assign map_wr = i_req.wr && in_win && pg_stat &&
                  (i_req.addr == `PCW_MAP_OFS);

  // parallel pages 1/4, 2/5, 3/6 share one slot of a socket
  assign pg_delta = pg_lo ? (i_req.page - `PCW_PAGE_LO_FIRST)
                          : (i_req.page - `PCW_PAGE_HI_FIRST);
  assign slot = pg_delta[1:0];

  // two host bytes per card byte: drop address bit 0
  assign card_ofs = {i_req.page[5:0], i_req.addr[14:1]};

  // card status byte, unused bits read zero
  always_comb
  begin
    stat_byte = 8'h00;
    stat_byte[`PCW_ST_DET0] = i_card_detect_n[0];
    stat_byte[`PCW_ST_DET1] = i_card_detect_n[1];
    stat_byte[`PCW_ST_BVD0] = i_card_bvd[0];
    stat_byte[`PCW_ST_BVD1] = i_card_bvd[1];
    stat_byte[`PCW_ST_WAIT] = i_card_wait_n;
  end

  // next state: strobes default low, latches hold
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.flash_sel = 1'b0;
    nxt_st.ram_sel = 1'b0;
    nxt_st.card_sel = 1'b0;
    nxt_st.flash_we = 1'b0;
    nxt_st.prog_fail = 1'b0;
    nxt_st.rvalid = 1'b0;
    if (acc && in_win)
    begin
      if (pg_lo || pg_hi)
      begin
        // 32 Kbyte window inside the chosen slot
        nxt_st.mem_addr = {slot, i_req.addr[14:0]};
        if (to_ram)
        begin
          nxt_st.ram_sel = 1'b1;
        end
        else if (i_req.wr && !prog_ok)
        begin
          nxt_st.prog_fail = 1'b1;
        end
        else
        begin
          nxt_st.flash_sel = 1'b1;
          nxt_st.flash_we = i_req.wr;
        end
      end
      else if (pg_card)
      begin
        nxt_st.card_sel = 1'b1;
        nxt_st.card_addr = {st_ff.bank, card_ofs};
      end
      else if (stat_rd)
      begin
        nxt_st.rdata = stat_byte;
        nxt_st.rvalid = 1'b1;
      end
      else if (bank_wr)
      begin
        nxt_st.bank = i_req.wdata[4:0];
      end
      else if (map_wr)
      begin
        nxt_st.map_dl = i_req.wdata[0];
      end
    end
    // cleanup overrides a layout latch write in the same cycle; bank writes still load
    if (i_factory_cleanup)
    begin
      nxt_st.map_dl = `PCW_MAP_STD;
    end
  end

  // state register, standard layout and bank zero after reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_ff <= '0;
      st_ff.map_dl <= `PCW_MAP_STD;
      st_ff.bank <= `PCW_BANK_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign o_map_download = st_ff.map_dl;
  assign o_card_bank = st_ff.bank;
  assign o_flash_sel = st_ff.flash_sel;
  assign o_ram_sel = st_ff.ram_sel;
  assign o_card_sel = st_ff.card_sel;
  assign o_flash_we = st_ff.flash_we;
  assign o_prog_fail = st_ff.prog_fail;
  assign o_mem_addr = st_ff.mem_addr;
  assign o_card_addr = st_ff.card_addr;
  assign o_rdata = st_ff.rdata;
  assign o_rdata_valid = st_ff.rvalid;

  // checks on the decoder, all in the i_clk domain
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic swap_acc;
  logic card_acc;
  logic [4:0] wdata_bank;
  assign swap_acc = acc && in_win && (pg_lo || pg_hi);
  assign card_acc = acc && in_win && pg_card;
  assign wdata_bank = i_req.wdata[4:0];

  sequence seq_stat_req;
    stat_rd;
  endsequence

  sequence seq_stat_ans;
    o_rdata_valid && (o_rdata[`PCW_ST_DET0] == $past(i_card_detect_n[0]))
      && (o_rdata[`PCW_ST_DET1] == $past(i_card_detect_n[1]));
  endsequence

  download_route_a: assert property (
    swap_acc && st_ff.map_dl && !i_factory_cleanup |=>
      (o_ram_sel == $past(pg_hi)) && !(o_flash_sel && o_ram_sel))
    else $error("download layout routed a page to the wrong socket");

  standard_route_a: assert property (
    swap_acc && !st_ff.map_dl |=> o_ram_sel == $past(pg_lo))
    else $error("standard layout routed a page to the wrong socket");

  map_latch_hold_a: assert property (
    !map_wr && !i_factory_cleanup |=> $stable(o_map_download))
    else $error("layout latch changed without a write");

  map_latch_load_a: assert property (
    map_wr && !i_factory_cleanup |=> o_map_download == $past(i_req.wdata[0]))
    else $error("layout latch did not take the written value");

  cleanup_std_a: assert property (
    i_factory_cleanup |=> o_map_download == `PCW_MAP_STD)
    else $error("standard layout not in effect after cleanup");

  page_slot_a: assert property (
    swap_acc |=> (o_mem_addr[16:15] == $past(slot)) &&
      (o_mem_addr[14:0] == $past(i_req.addr[14:0])) && $past(slot) != 2'h3)
    else $error("swappable page window address wrong");

  prog_gate_a: assert property (
    swap_acc && i_req.wr && !to_ram && !prog_ok |=>
      o_prog_fail && !o_flash_we && !o_flash_sel)
    else $error("flash write not refused with switches off");

  prog_allow_a: assert property (
    o_flash_we |-> $past(prog_ok) && $past(i_req.wr))
    else $error("flash write enabled without all switches");

  card_bank_a: assert property (
    o_card_sel |-> o_card_addr[24:20] == $past(o_card_bank))
    else $error("card bank bits do not match the bank field");

  card_window_a: assert property (
    acc && in_win && pg_card |=> o_card_sel ##1 !o_card_sel || $past(pg_card))
    else $error("card window not selected for pages 80 to BF");

  card_double_a: assert property (
    o_card_sel |-> o_card_addr[19:0] == $past(card_ofs))
    else $error("card byte not mapped onto two host bytes");

  status_read_a: assert property (
    seq_stat_req |=> seq_stat_ans)
    else $error("status read answer wrong");

  status_batt_a: assert property (
    seq_stat_req |=> (o_rdata[`PCW_ST_BVD1:`PCW_ST_BVD0] == $past(i_card_bvd))
      && (o_rdata[`PCW_ST_WAIT] == $past(i_card_wait_n)))
    else $error("status battery or wait bits wrong");

  bank_hold_a: assert property (
    !bank_wr |=> $stable(o_card_bank))
    else $error("bank field changed without a write");

  bank_load_a: assert property (
    bank_wr |=> o_card_bank == $past(wdata_bank))
    else $error("bank field did not take the written value");

  // at most one target answers any request
  one_target_a: assert property (
    $onehot0({o_flash_sel, o_ram_sel, o_card_sel,
      o_rdata_valid, o_prog_fail}))
    else $error("more than one target answered a request");

  // the upper half of a page reaches no paged target
  upper_half_a: assert property (
    acc && !in_win |=> !o_flash_sel && !o_ram_sel && !o_card_sel &&
      !o_rdata_valid && !o_prog_fail)
    else $error("request outside the paged window was answered");

  // flash reads pass whatever the switches say
  flash_read_a: assert property (
    swap_acc && i_req.rd && !to_ram |=> o_flash_sel && !o_flash_we &&
      !o_prog_fail)
    else $error("flash read refused or turned into a write");

  // a status answer only follows a status read
  status_only_a: assert property (
    o_rdata_valid |-> $past(stat_rd))
    else $error("status answer without a status read");

  // a card select only follows a card window request
  card_only_a: assert property (
    o_card_sel |-> $past(card_acc))
    else $error("card selected outside pages 80 to BF");

endmodule : pcw_page_map

// ### pcw_card_model.sv
/*
  card side model of the page map and card window decoder: presents the
  card detect, battery detect and wait levels of a seated or a missing
  card.
  assumes the bench chooses the card state with i_present.
*/
`timescale 1ns/10ps
module pcw_card_model (
  input wire logic i_present,
  output logic [1:0] o_card_detect_n,
  output logic [1:0] o_card_bvd,
  output logic o_card_wait_n
);
  // seated card: detects low, battery good, wait idle high
  always_comb
  begin
    if (i_present)
    begin
      o_card_detect_n = 2'h0;
      o_card_bvd = 2'h3;
      o_card_wait_n = 1'h1;
    end
    else
    begin
      // half seated, weak battery, busy: detect bit 1, battery bit 1 and wait off the good pattern
      o_card_detect_n = 2'h2;
      o_card_bvd = 2'h1;
      o_card_wait_n = 1'h0;
    end
  end
endmodule : pcw_card_model

// ### pcw_page_map_tb_top.sv
/*
  self-checking bench of the page map and card window decoder.
  assumes pcw_pkg, pcw_page_map and the card model pcw_card_model.
*/
`timescale 1ns/10ps
module pcw_page_map_tb_top
  import pcw_pkg::*;
;
  logic i_clk, i_rst, i_factory_cleanup, card_present;
  logic i_sw_flash_we, i_sw_cfg_a, i_sw_cfg_b, i_card_wait_n;
  logic [1:0] i_card_detect_n, i_card_bvd;
  pcw_req_t i_req;
  logic o_map_download, o_flash_sel, o_ram_sel, o_card_sel;
  logic o_flash_we, o_prog_fail, o_rdata_valid;
  logic [4:0] o_card_bank;
  logic [16:0] o_mem_addr;
  logic [24:0] o_card_addr;
  logic [7:0] o_rdata;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [7:0] win_pg [4] = '{8'h7F, 8'h80, 8'hBF, 8'hC0};
  logic win_sel [4] = '{1'h0, 1'h1, 1'h1, 1'h0};
  logic [7:0] st_exp [2] = '{8'h12, 8'hB0};

  pcw_page_map u_pcw_page_map (.i_clk(i_clk), .i_rst(i_rst),
    .i_req(i_req), .i_factory_cleanup(i_factory_cleanup),
    .i_sw_flash_we(i_sw_flash_we), .i_sw_cfg_a(i_sw_cfg_a),
    .i_sw_cfg_b(i_sw_cfg_b), .i_card_detect_n(i_card_detect_n),
    .i_card_bvd(i_card_bvd), .i_card_wait_n(i_card_wait_n),
    .o_map_download(o_map_download), .o_card_bank(o_card_bank),
    .o_flash_sel(o_flash_sel), .o_ram_sel(o_ram_sel),
    .o_card_sel(o_card_sel), .o_flash_we(o_flash_we),
    .o_prog_fail(o_prog_fail), .o_mem_addr(o_mem_addr),
    .o_card_addr(o_card_addr), .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid));

  pcw_card_model u_pcw_card_model (.i_present(card_present),
    .o_card_detect_n(i_card_detect_n), .o_card_bvd(i_card_bvd),
    .o_card_wait_n(i_card_wait_n));

  // 20 MHz clock
  initial
  begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one host cycle; answers stand in the cycle after the strobe
  task automatic op(input logic [7:0] pg, input logic [15:0] ad,
                    input logic [7:0] wd, input logic rd, input logic wr);
    @(negedge i_clk);
    i_req = '{page: pg, addr: ad, wdata: wd, rd: rd, wr: wr};
    @(negedge i_clk);
    i_req.rd = 1'h0;
    i_req.wr = 1'h0;
  endtask : op

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // watchdog far beyond the few dozen cycles of the tests
  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial
  begin
    i_rst = 1'h1;
    i_req = '0;
    i_factory_cleanup = 1'h0;
    {i_sw_flash_we, i_sw_cfg_a, i_sw_cfg_b} = 3'h7;
    card_present = 1'h0;
    repeat (6) @(negedge i_clk);
    i_rst = 1'h0;
    chk("map", o_map_download, 1'h0);
    chk("bank", o_card_bank, 5'h00);
    // standard layout
    op(8'h02, 16'h0123, 8'h5A, 1'h0, 1'h1);
    chk("sel", {o_flash_sel, o_ram_sel, o_flash_we}, 3'h2);
    chk("mem_addr", o_mem_addr, {2'h1, 15'h0123});
    op(8'h05, 16'h0123, 8'h5A, 1'h0, 1'h1);
    chk("sel", {o_flash_sel, o_flash_we, o_prog_fail}, 3'h6);
    chk("mem_addr", o_mem_addr, {2'h1, 15'h0123});
    // upper half of a page lies outside the 32 Kbyte window
    op(8'h02, 16'h8123, 8'h5A, 1'h0, 1'h1);
    chk("upper", {o_flash_sel, o_ram_sel, o_prog_fail}, 3'h0);
    // each switch off in turn refuses the flash write
    for (int k = 0; k < 3; k++)
    begin
      {i_sw_flash_we, i_sw_cfg_a, i_sw_cfg_b} = 3'h7 ^ (3'h1 << k);
      op(8'h06, 16'h0010, 8'h00, 1'h0, 1'h1);
      chk("deny", {o_flash_sel, o_flash_we, o_prog_fail}, 3'h1);
    end
    // a flash read still passes with a switch off
    op(8'h06, 16'h0010, 8'h00, 1'h1, 1'h0);
    chk("read", {o_flash_sel, o_flash_we, o_prog_fail}, 3'h4);
    {i_sw_flash_we, i_sw_cfg_a, i_sw_cfg_b} = 3'h7;
    // download layout
    op(8'h30, 16'h0002, 8'h01, 1'h0, 1'h1);
    chk("map", o_map_download, 1'h1);
    op(8'h01, 16'h7FFF, 8'h00, 1'h0, 1'h1);
    chk("sel", {o_flash_sel, o_ram_sel, o_flash_we}, 3'h5);
    chk("mem_addr", o_mem_addr, {2'h0, 15'h7FFF});
    op(8'h06, 16'h0000, 8'h00, 1'h1, 1'h0);
    chk("sel", {o_flash_sel, o_ram_sel, o_flash_we}, 3'h2);
    chk("mem_addr", o_mem_addr, {2'h2, 15'h0000});
    // cleanup beats a latch write in the same cycle
    i_factory_cleanup = 1'h1;
    op(8'h30, 16'h0002, 8'h01, 1'h0, 1'h1);
    i_factory_cleanup = 1'h0;
    chk("map", o_map_download, 1'h0);
    // bank field and card window
    op(8'h30, 16'h0001, 8'hFF, 1'h0, 1'h1);
    chk("bank", o_card_bank, 5'h1F);
    op(8'h30, 16'h0000, 8'h03, 1'h0, 1'h1);
    chk("bank", o_card_bank, 5'h1F);
    op(8'h81, 16'h0005, 8'h00, 1'h1, 1'h0);
    chk("card_addr", o_card_addr, {5'h1F, 6'h01, 14'h0002});
    for (int k = 0; k < 4; k++)
    begin
      op(win_pg[k], 16'h7FFE, 8'h00, 1'h1, 1'h0);
      chk("card_sel", o_card_sel, win_sel[k]);
    end
    chk("card_addr", o_card_addr, {5'h1F, 6'h3F, 14'h3FFF});
    op(8'h30, 16'h0001, 8'h04, 1'h0, 1'h1);
    op(8'h80, 16'h0000, 8'h00, 1'h1, 1'h0);
    chk("card_addr", o_card_addr, {5'h04, 6'h00, 14'h0000});
    // status byte for a missing and a seated card
    for (int p = 0; p < 2; p++)
    begin
      card_present = p[0];
      op(8'h30, 16'h0000, 8'h00, 1'h1, 1'h0);
      chk("valid", o_rdata_valid, 1'h1);
      chk("status", o_rdata, st_exp[p]);
      chk("present", (o_rdata & 8'hB3) == 8'hB0, p[0]);
    end
    op(8'h30, 16'h0001, 8'h00, 1'h1, 1'h0);
    chk("valid", o_rdata_valid, 1'h0);
    op(8'h31, 16'h0000, 8'h00, 1'h1, 1'h0);
    chk("valid", o_rdata_valid, 1'h0);
    finish_test();
  end
endmodule : pcw_page_map_tb_top
